// File: rtl/cfdfc_defines.vh
// Summary of operation
// [RULE1] Bit after identifier recessive means FD frame
// [RULE2] FD: res dominant, BRS recessive switches rate
// [RULE3] FDF and res recessive set exception flag
// [RULE4] Exception, handling enabled: receiver goes integrating
// [RULE5] Exception, handling disabled: form error, error frame
// [RULE6] Classic always allowed; buffer flag picks format
// [RULE7] FD disabled: received FD frame gets error
// [RULE8] FD disabled: buffer flags ignored, classic sent
// [RULE9] FD on, switching off: FD without switching
// [RULE10] FD and switching on: both flags switch rate
// [RULE11] FD enables writable only in init with change
// [RULE12] DLC 9..15 map to 12..64 bytes
// [RULE13] Data timing after BRS until delimiter/error
// [RULE14] ESI recessive when error passive at start
// [RULE15] Compare at secondary point, act next sample
// [RULE16] Compensation only in data phase when enabled
// [RULE17] Secondary point is delay plus offset
// [RULE18] Compensation value saturates at 127 quanta
// [RULE19] Software keeps offset plus delay under 6 bits
// [RULE20] Value clears on init, updates each FD send; code measures only while delay_comp_enable is set
// [RULE21] Measure from sent FDF/res edge to rx edge
// [RULE22] Filter window ignores early dominant rx edges
// [RULE23] One quantum equals one core clock period
`ifndef CFDFC_DEFINES_VH
`define CFDFC_DEFINES_VH

`define CFDFC_RECESSIVE    1'h1
`define CFDFC_DOMINANT     1'h0
`define CFDFC_ACT_INTEG    2'h0
`define CFDFC_ACT_RX       2'h2
`define CFDFC_TDC_MAX      7'h7F
`define CFDFC_TDC_RST      7'h00
`define CFDFC_HIST_LEN     128
`define CFDFC_ST_IDLE      2'h1
`define CFDFC_ST_MEAS      2'h2
`define CFDFC_DLC_CLASSIC  4'h8
`define CFDFC_BYTES_12     7'h0C
`define CFDFC_BYTES_16     7'h10
`define CFDFC_BYTES_20     7'h14
`define CFDFC_BYTES_24     7'h18
`define CFDFC_BYTES_32     7'h20
`define CFDFC_BYTES_48     7'h30
`define CFDFC_BYTES_64     7'h40

`endif

// File: rtl/cfdfc_dlc_decode.v
`include "cfdfc_defines.vh"
`default_nettype none
module cfdfc_dlc_decode (
    input  wire       fd_frame,
    input  wire [3:0] dlc,
    output reg  [6:0] num_bytes
);
    always @* begin
        if (dlc <= `CFDFC_DLC_CLASSIC) begin
            num_bytes = {3'h0, dlc};
        end else if (!fd_frame) begin
            num_bytes = {3'h0, `CFDFC_DLC_CLASSIC};
        end else begin
            case (dlc) // RULE12
                4'h9:    num_bytes = `CFDFC_BYTES_12;
                4'hA:    num_bytes = `CFDFC_BYTES_16;
                4'hB:    num_bytes = `CFDFC_BYTES_20;
                4'hC:    num_bytes = `CFDFC_BYTES_24;
                4'hD:    num_bytes = `CFDFC_BYTES_32;
                4'hE:    num_bytes = `CFDFC_BYTES_48;
                default: num_bytes = `CFDFC_BYTES_64;
            endcase
        end
    end
endmodule // cfdfc_dlc_decode
`default_nettype wire

// File: rtl/cfdfc_core.v
`include "cfdfc_defines.vh"
`default_nettype none
module cfdfc_core (
    input  wire       clk,
    input  wire       rst_n,
    // Configuration
    input  wire       init_request,
    input  wire       config_change_enable,
    input  wire       cfg_write,
    input  wire       fd_operation_enable_wr,
    input  wire       bit_rate_switch_enable_wr,
    input  wire       protocol_exception_disable,
    input  wire       delay_comp_enable,
    input  wire [6:0] delay_comp_offset,
    input  wire [6:0] delay_comp_filter_window,
    input  wire       exception_flag_clear,
    // Bit stream events
    input  wire       sample_point,
    input  wire       rx_bit,
    input  wire       at_fdf_bit,
    input  wire       at_res_bit,
    input  wire       at_brs_bit,
    input  wire       at_crc_delim,
    input  wire       error_detected,
    input  wire [1:0] activity_in,
    input  wire [3:0] rx_dlc,
    // Transmit side
    input  wire       tx_start,
    input  wire       tx_active,
    input  wire       buf_fdf,
    input  wire       buf_brs,
    input  wire [3:0] tx_dlc,
    input  wire       error_passive,
    input  wire       tx_fdf_res_edge,
    input  wire       data_bit_start,
    // Pins
    input  wire       can_tx,
    input  wire       can_rx,
    // Outputs
    output reg        fd_operation_enable_q,
    output reg        bit_rate_switch_enable_q,
    output reg        rx_fd_frame_q,
    output reg        rx_brs_q,
    output reg        form_error_q,
    output reg        protocol_exception_flag_q,
    output reg  [1:0] protocol_activity_state_q,
    output reg        tx_fd_frame_q,
    output reg        tx_brs_q,
    output reg        tx_esi_q,
    output reg        data_timing_sel_q,
    output reg  [6:0] rx_data_bytes_q,
    output reg  [6:0] tx_data_bytes_q,
    output reg  [6:0] delay_comp_value_q,
    output wire       delay_comp_active,
    output wire       secondary_sample_point,
    output reg        ssp_bit_error_q
);

    ////////////////////////////////////////////////////////////////////////
    // Measurement states
    localparam [1:0] ST_IDLE = `CFDFC_ST_IDLE;
    localparam [1:0] ST_MEAS = `CFDFC_ST_MEAS;

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    reg                        fd_operation_enable_d;
    reg                        bit_rate_switch_enable_d;
    reg                        rx_fd_frame_d;
    reg                        rx_res_dom_q;
    reg                        rx_res_dom_d;
    reg                        rx_brs_d;
    reg                        form_error_d;
    reg                        protocol_exception_flag_d;
    reg                        exc_pend_q;
    reg                        exc_pend_d;
    reg  [1:0]                 protocol_activity_state_d;
    reg                        tx_fd_frame_d;
    reg                        tx_brs_d;
    reg                        tx_esi_d;
    reg                        data_timing_sel_d;
    reg  [6:0]                 delay_comp_value_d;
    reg  [1:0]                 state_q;
    reg  [1:0]                 state_d;
    reg  [6:0]                 meas_q;
    reg  [6:0]                 meas_d;
    reg  [`CFDFC_HIST_LEN-1:0] tx_hist_q;
    reg  [`CFDFC_HIST_LEN-1:0] start_hist_q;
    reg                        ssp_pend_q;
    reg                        ssp_pend_d;
    reg                        ssp_bit_error_d;
    wire [7:0]                 pos_sum;
    wire [6:0]                 ssp_pos;
    wire                       meas_stop;
    wire                       tx_delayed;
    wire                       cfg_open;
    wire                       fdf_seen;
    wire [6:0]                 rx_bytes_w;
    wire [6:0]                 tx_bytes_w;
    wire                       meas_start;
    wire                       tdc_zero;
    wire [6:0]                 hist_idx;

    assign cfg_open = init_request & config_change_enable;
    assign fdf_seen = (rx_bit == `CFDFC_RECESSIVE);

    ////////////////////////////////////////////////////////////////////////
    // Data length decoders
    cfdfc_dlc_decode u_rx_dlc (
        .fd_frame  (rx_fd_frame_q),
        .dlc       (rx_dlc),
        .num_bytes (rx_bytes_w)
    );

    cfdfc_dlc_decode u_tx_dlc (
        .fd_frame  (tx_fd_frame_q),
        .dlc       (tx_dlc),
        .num_bytes (tx_bytes_w)
    );

    ////////////////////////////////////////////////////////////////////////
    // Protected configuration
    always @* begin
        fd_operation_enable_d    = fd_operation_enable_q;
        bit_rate_switch_enable_d = bit_rate_switch_enable_q;
        if (cfg_write && cfg_open) begin // RULE11
            fd_operation_enable_d    = fd_operation_enable_wr;
            bit_rate_switch_enable_d = bit_rate_switch_enable_wr;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Receive format decode and protocol exception
    always @* begin
        rx_fd_frame_d             = rx_fd_frame_q;
        rx_res_dom_d              = rx_res_dom_q;
        rx_brs_d                  = rx_brs_q;
        form_error_d              = 1'h0;
        exc_pend_d                = exc_pend_q;
        protocol_exception_flag_d = protocol_exception_flag_q;
        protocol_activity_state_d = activity_in;
        if (exception_flag_clear) begin
            protocol_exception_flag_d = 1'h0;
        end
        if (at_fdf_bit) begin
            // Classic decode when FD is off, FD frame then errors
            rx_fd_frame_d = fdf_seen & fd_operation_enable_q; // RULE1
            rx_res_dom_d  = 1'h0;
            rx_brs_d      = 1'h0;
            if (fdf_seen && !fd_operation_enable_q) begin
                form_error_d = 1'h1; // RULE7
            end
        end
        if (at_res_bit && rx_fd_frame_q) begin
            rx_res_dom_d = (rx_bit == `CFDFC_DOMINANT);
            if (rx_bit == `CFDFC_RECESSIVE) begin
                protocol_exception_flag_d = 1'h1; // RULE3
                if (protocol_exception_disable) begin
                    form_error_d = 1'h1; // RULE5
                end else begin
                    exc_pend_d = 1'h1;
                end
            end
        end
        if (at_brs_bit && rx_fd_frame_q) begin
            rx_brs_d = rx_res_dom_q & (rx_bit == `CFDFC_RECESSIVE); // RULE2
        end
        // Pending exception waits for the following sample point
        if (exc_pend_q && sample_point && !at_res_bit) begin
            exc_pend_d = 1'h0;
            if (activity_in == `CFDFC_ACT_RX) begin
                protocol_activity_state_d = `CFDFC_ACT_INTEG; // RULE4
            end
        end
        if (init_request) begin
            exc_pend_d = 1'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Transmit format selection, latched at frame start
    always @* begin
        tx_fd_frame_d = tx_fd_frame_q;
        tx_brs_d      = tx_brs_q;
        tx_esi_d      = tx_esi_q;
        if (tx_start) begin
            tx_fd_frame_d = fd_operation_enable_q & buf_fdf; // RULE6 RULE8 RULE9
            tx_brs_d      = fd_operation_enable_q & bit_rate_switch_enable_q
                            & buf_fdf & buf_brs; // RULE10
            tx_esi_d      = error_passive ? `CFDFC_RECESSIVE : `CFDFC_DOMINANT; // RULE14
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bit timing selection
    always @* begin
        data_timing_sel_d = data_timing_sel_q;
        if (at_brs_bit) begin
            if (tx_active) begin
                data_timing_sel_d = tx_brs_q; // RULE13
            end else begin
                data_timing_sel_d = rx_fd_frame_q & rx_res_dom_q
                                    & (rx_bit == `CFDFC_RECESSIVE); // RULE13
            end
        end
        if (at_crc_delim || error_detected || init_request) begin
            data_timing_sel_d = 1'h0; // RULE13
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Loop delay measurement, one quantum per core clock
    assign pos_sum = {1'h0, meas_q} + {1'h0, delay_comp_offset}; // RULE17 RULE23
    assign ssp_pos = pos_sum[7] ? `CFDFC_TDC_MAX : pos_sum[6:0]; // RULE18
    // Early dominant glitches are ignored below the window
    assign meas_stop = ((can_rx == `CFDFC_DOMINANT) && (ssp_pos >= delay_comp_filter_window))
                       || (meas_q == `CFDFC_TDC_MAX); // RULE22
    assign meas_start = tx_fdf_res_edge & tx_active & tx_fd_frame_q & delay_comp_enable; // RULE20 RULE21

    always @* begin
        state_d            = state_q;
        meas_d             = meas_q;
        delay_comp_value_d = delay_comp_value_q;
        case (state_q)
            ST_IDLE: begin
                if (meas_start) begin
                    state_d = ST_MEAS; // RULE21
                    meas_d  = 7'h00;
                end
            end
            ST_MEAS: begin
                if (meas_stop) begin
                    state_d            = ST_IDLE;
                    delay_comp_value_d = ssp_pos; // RULE20
                end else begin
                    meas_d = meas_q + 7'h01; // RULE21
                end
                if (error_detected || !tx_active) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
        if (init_request) begin
            state_d            = ST_IDLE;
            delay_comp_value_d = `CFDFC_TDC_RST; // RULE20
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Secondary sample point and delayed transmit compare
    assign delay_comp_active = delay_comp_enable & data_timing_sel_q & tx_active; // RULE16

    // Zero delay taps the live signals
    assign tdc_zero   = (delay_comp_value_q == `CFDFC_TDC_RST);
    assign hist_idx   = delay_comp_value_q - 7'h01;
    assign tx_delayed = tdc_zero ? can_tx : tx_hist_q[hist_idx];
    assign secondary_sample_point = delay_comp_active
                        & (tdc_zero ? data_bit_start : start_hist_q[hist_idx]); // RULE17

    always @* begin
        ssp_pend_d      = ssp_pend_q;
        ssp_bit_error_d = 1'h0;
        if (sample_point) begin
            ssp_bit_error_d = ssp_pend_q; // RULE15
            ssp_pend_d      = 1'h0;
        end
        // A new mismatch in the same cycle is kept for the next point
        if (secondary_sample_point && (can_rx != tx_delayed)) begin
            ssp_pend_d = 1'h1; // RULE15
        end
        if (!delay_comp_active) begin
            ssp_pend_d = 1'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fd_operation_enable_q     <= 1'h0;
            bit_rate_switch_enable_q  <= 1'h0;
            rx_fd_frame_q             <= 1'h0;
            rx_res_dom_q              <= 1'h0;
            rx_brs_q                  <= 1'h0;
            form_error_q              <= 1'h0;
            protocol_exception_flag_q <= 1'h0;
            exc_pend_q                <= 1'h0;
            protocol_activity_state_q <= `CFDFC_ACT_INTEG;
            tx_fd_frame_q             <= 1'h0;
            tx_brs_q                  <= 1'h0;
            tx_esi_q                  <= `CFDFC_DOMINANT;
            data_timing_sel_q         <= 1'h0;
            rx_data_bytes_q           <= 7'h00;
            tx_data_bytes_q           <= 7'h00;
            delay_comp_value_q        <= `CFDFC_TDC_RST;
            state_q                   <= ST_IDLE;
            meas_q                    <= 7'h00;
            tx_hist_q                 <= {`CFDFC_HIST_LEN{1'h1}};
            start_hist_q              <= {`CFDFC_HIST_LEN{1'h0}};
            ssp_pend_q                <= 1'h0;
            ssp_bit_error_q           <= 1'h0;
        end else begin
            fd_operation_enable_q     <= fd_operation_enable_d;
            bit_rate_switch_enable_q  <= bit_rate_switch_enable_d;
            rx_fd_frame_q             <= rx_fd_frame_d;
            rx_res_dom_q              <= rx_res_dom_d;
            rx_brs_q                  <= rx_brs_d;
            form_error_q              <= form_error_d;
            protocol_exception_flag_q <= protocol_exception_flag_d;
            exc_pend_q                <= exc_pend_d;
            protocol_activity_state_q <= protocol_activity_state_d;
            tx_fd_frame_q             <= tx_fd_frame_d;
            tx_brs_q                  <= tx_brs_d;
            tx_esi_q                  <= tx_esi_d;
            data_timing_sel_q         <= data_timing_sel_d;
            rx_data_bytes_q           <= rx_bytes_w;
            tx_data_bytes_q           <= tx_bytes_w;
            delay_comp_value_q        <= delay_comp_value_d;
            state_q                   <= state_d;
            meas_q                    <= meas_d;
            tx_hist_q                 <= {tx_hist_q[`CFDFC_HIST_LEN-2:0], can_tx};
            start_hist_q              <= {start_hist_q[`CFDFC_HIST_LEN-2:0], data_bit_start};
            ssp_pend_q                <= ssp_pend_d;
            ssp_bit_error_q           <= ssp_bit_error_d;
        end
    end

endmodule // cfdfc_core
`default_nettype wire

// File: bench/cfdfc_xcvr_model.sv
`default_nettype none
module cfdfc_xcvr_model (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       can_tx,
    input  wire logic [6:0] loop_dly,
    input  wire logic       corrupt,
    output wire logic       can_rx
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [127:0] line_q;
    // Echo path of the transceiver, idles recessive
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            line_q <= '1;
        end else begin
            line_q <= {line_q[126:0], can_tx};
        end
    end
    // Corrupt flips the echo only when a test asks
    assign can_rx = line_q[loop_dly] ^ corrupt;
endmodule // cfdfc_xcvr_model
`default_nettype wire

// File: bench/cfdfc_asserts.sv
`default_nettype none
module cfdfc_asserts (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       init_request,
    input wire logic       config_change_enable,
    input wire logic       cfg_write,
    input wire logic       fd_operation_enable_wr,
    input wire logic       protocol_exception_disable,
    input wire logic       rx_bit,
    input wire logic       at_fdf_bit,
    input wire logic       at_res_bit,
    input wire logic       tx_start,
    input wire logic       buf_fdf,
    input wire logic       buf_brs,
    input wire logic       fd_operation_enable_q,
    input wire logic       bit_rate_switch_enable_q,
    input wire logic       rx_fd_frame_q,
    input wire logic       form_error_q,
    input wire logic       protocol_exception_flag_q,
    input wire logic       tx_fd_frame_q,
    input wire logic       tx_brs_q,
    input wire logic [6:0] delay_comp_value_q
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_res_rec;
        at_res_bit && rx_fd_frame_q && rx_bit;
    endsequence
    sequence s_fd_off;
        at_fdf_bit && rx_bit && !fd_operation_enable_q;
    endsequence
    property p_cfg_keep;
        cfg_write && !(init_request && config_change_enable) |=>
            $stable(fd_operation_enable_q) && $stable(bit_rate_switch_enable_q);
    endproperty
    a_cfg_keep: assert property (p_cfg_keep) else $error("refused write took");
    property p_cfg_take;
        cfg_write && init_request && config_change_enable |=> fd_operation_enable_q == $past(fd_operation_enable_wr);
    endproperty
    a_cfg_take: assert property (p_cfg_take) else $error("write lost");
    property p_tx_fd;
        tx_start |=> tx_fd_frame_q == ($past(fd_operation_enable_q) && $past(buf_fdf));
    endproperty
    a_tx_fd: assert property (p_tx_fd) else $error("tx format wrong");
    property p_tx_brs;
        tx_start |=> tx_brs_q == ($past(bit_rate_switch_enable_q) && $past(tx_start) && $past(buf_brs) && tx_fd_frame_q);
    endproperty
    a_tx_brs: assert property (p_tx_brs) else $error("tx switch wrong");
    property p_fd_off;
        s_fd_off |=> form_error_q;
    endproperty
    a_fd_off: assert property (p_fd_off) else $error("fd frame not refused");
    property p_pxe;
        s_res_rec |=> protocol_exception_flag_q;
    endproperty
    a_pxe: assert property (p_pxe) else $error("exception not flagged");
    property p_pxhd;
        (s_res_rec ##0 protocol_exception_disable) |=> form_error_q;
    endproperty
    a_pxhd: assert property (p_pxhd) else $error("no form error");
    property p_tdc_clr;
        init_request |=> delay_comp_value_q == 7'h00;
    endproperty
    a_tdc_clr: assert property (p_tdc_clr) else $error("value not cleared");
endmodule // cfdfc_asserts
`default_nettype wire

// File: bench/tb_top.sv
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk, rst_n, init_request, config_change_enable, cfg_write, fd_operation_enable_wr;
    logic       bit_rate_switch_enable_wr, protocol_exception_disable, delay_comp_enable, exception_flag_clear;
    logic       sample_point, rx_bit, at_fdf_bit, at_res_bit, at_brs_bit, at_crc_delim, error_detected;
    logic       tx_start, tx_active, buf_fdf, buf_brs, error_passive, tx_fdf_res_edge, data_bit_start;
    logic       can_tx, can_rx, corrupt, fd_operation_enable_q, bit_rate_switch_enable_q, rx_fd_frame_q;
    logic       rx_brs_q, form_error_q, protocol_exception_flag_q, tx_fd_frame_q, tx_brs_q, tx_esi_q;
    logic       data_timing_sel_q, delay_comp_active, secondary_sample_point, ssp_bit_error_q;
    logic [1:0] activity_in, protocol_activity_state_q;
    logic [3:0] rx_dlc, tx_dlc;
    logic [6:0] delay_comp_offset, delay_comp_filter_window, loop_dly, rx_data_bytes_q;
    logic [6:0] tx_data_bytes_q, delay_comp_value_q, base, v;
    int         error_cnt = 0;
    int         tests_run = 0;
    int         cyc = 0;

    cfdfc_core cfdfc_core_inst (.*);
    cfdfc_xcvr_model cfdfc_xcvr_model_inst (.*);

    initial begin
        clk = 1'h0;
        forever #2 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////
    task automatic tick(input int n = 1);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic pulse(ref logic s);
        s = 1'h1;
        tick();
        s = 1'h0;
    endtask
    task automatic chk(input logic [6:0] got, input logic [6:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cfg(input logic cce, input logic fd, input logic br);
        {init_request, config_change_enable, cfg_write} = {1'h1, cce, 1'h1};
        {fd_operation_enable_wr, bit_rate_switch_enable_wr} = {fd, br};
        tick();
        {init_request, config_change_enable, cfg_write} = 3'h0;
    endtask
    // One-hot select: 4 FD format bit, 2 res, 1 BRS
    task automatic strobe(input logic [2:0] k, input logic b);
        rx_bit = b;
        {at_fdf_bit, at_res_bit, at_brs_bit} = k;
        tick();
        {at_fdf_bit, at_res_bit, at_brs_bit} = 3'h0;
    endtask
    task automatic txs(input logic f, input logic b, input logic e);
        {buf_fdf, buf_brs, error_passive} = {f, b, e};
        pulse(tx_start);
    endtask
    task automatic meas(input logic [6:0] d, input logic [6:0] o, input logic [6:0] w, output logic [6:0] r);
        {loop_dly, delay_comp_offset, delay_comp_filter_window} = {d, o, w};
        can_tx = 1'h0;
        pulse(tx_fdf_res_edge);
        tick(140);
        r = delay_comp_value_q;
        can_tx = 1'h1;
        tick(130);
    endtask
    function automatic logic [6:0] nbytes(input logic [3:0] d, input logic fd);
        logic [6:0] t[7] = '{7'h0C, 7'h10, 7'h14, 7'h18, 7'h20, 7'h30, 7'h40};
        if (d < 4'h9) return {3'h0, d};
        return fd ? t[d - 4'h9] : 7'h08;
    endfunction
    task automatic print_verdict;
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 8000) begin
            error_cnt++;
            print_verdict();
        end
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        {rst_n, init_request, config_change_enable, cfg_write, fd_operation_enable_wr, bit_rate_switch_enable_wr,
         protocol_exception_disable, delay_comp_enable, exception_flag_clear, sample_point, rx_bit, at_fdf_bit,
         at_res_bit, at_brs_bit, at_crc_delim, error_detected, tx_start, tx_active, buf_fdf, buf_brs,
         error_passive, tx_fdf_res_edge, data_bit_start, corrupt} = '0;
        {activity_in, rx_dlc, tx_dlc, delay_comp_offset, delay_comp_filter_window} = '0;
        loop_dly = 7'h03;
        can_tx = 1'h1;
        repeat (3) @(posedge clk);
        #1;
        rst_n = 1'h1;
        chk(delay_comp_value_q, 7'h00);
        for (int i = 0; i < 16; i++) begin
            cfg(1'h1, i[3], i[2]);
            tick();
            cfg(1'h0, !i[3], !i[2]);
            chk({fd_operation_enable_q, bit_rate_switch_enable_q}, 7'(i[3:2]));
            txs(i[1], i[0], i[0]);
            chk(tx_fd_frame_q, i[3] & i[1]);
            chk(tx_brs_q, &i[3:0]);
            chk(tx_esi_q, i[0]);
        end
        for (int d = 0; d < 16; d++) begin
            {rx_dlc, tx_dlc} = {4'(d), 4'(d)};
            tick();
            chk(rx_data_bytes_q, nbytes(4'(d), 1'h0));
            chk(tx_data_bytes_q, nbytes(4'(d), 1'h1));
        end
        cfg(1'h1, 1'h0, 1'h0);
        strobe(3'h4, 1'h1);
        chk(form_error_q, 1'h1);
        cfg(1'h1, 1'h1, 1'h1);
        strobe(3'h4, 1'h0);
        chk(rx_fd_frame_q, 1'h0);
        activity_in = 2'h2;
        strobe(3'h4, 1'h1);
        chk(rx_fd_frame_q, 1'h1);
        strobe(3'h2, 1'h1);
        chk({protocol_exception_flag_q, form_error_q}, 7'h2);
        chk(protocol_activity_state_q, 2'h2);
        chk(rx_data_bytes_q, nbytes(rx_dlc, 1'h1));
        pulse(sample_point);
        chk(protocol_activity_state_q, 2'h0);
        pulse(exception_flag_clear);
        protocol_exception_disable = 1'h1;
        strobe(3'h4, 1'h1);
        strobe(3'h2, 1'h1);
        chk(form_error_q, 1'h1);
        protocol_exception_disable = 1'h0;
        strobe(3'h4, 1'h1);
        strobe(3'h2, 1'h0);
        strobe(3'h1, 1'h1);
        chk({rx_brs_q, data_timing_sel_q}, 7'h3);
        pulse(error_detected);
        chk(data_timing_sel_q, 1'h0);
        delay_comp_enable = 1'h1;
        tx_active = 1'h1;
        txs(1'h1, 1'h1, 1'h0);
        // Offsets up to 7'h7D, beyond six data bits, to reach saturation
        meas(7'h03, 7'h00, 7'h00, base);
        meas(7'h03, 7'h09, 7'h00, v);
        chk(v, base + 7'h09);
        meas(7'h06, 7'h00, 7'h00, v);
        chk(v, base + 7'h03);
        meas(7'h03, 7'h7D, 7'h00, v);
        chk(v, 7'h7F);
        meas(7'h03, 7'h00, 7'h28, v);
        chk(v, 7'h28);
        chk(delay_comp_active, 1'h0);
        strobe(3'h1, 1'h1);
        chk({data_timing_sel_q, delay_comp_active}, 7'h3);
        for (int c = 0; c < 2; c++) begin
            corrupt = c[0];
            pulse(data_bit_start);
            tick(int'(v) - 2);
            chk(secondary_sample_point, 1'h0);
            tick();
            chk(secondary_sample_point, 1'h1);
            tick(5);
            pulse(sample_point);
            chk(ssp_bit_error_q, c[0]);
        end
        corrupt = 1'h0;
        delay_comp_enable = 1'h0;
        tick();
        chk(delay_comp_active, 1'h0);
        pulse(at_crc_delim);
        chk(data_timing_sel_q, 1'h0);
        cfg(1'h1, 1'h1, 1'h1);
        chk(delay_comp_value_q, 7'h00);
        print_verdict();
    end
endmodule // tb_top
bind cfdfc_core cfdfc_asserts cfdfc_asserts_inst (.*);
`default_nettype wire
